// >>> verilog/tdmo_mapper.v
// The placing of the registers and the Wishbone register port were chosen for this implementation.
`timescale 1ns/1ns
`default_nettype none
`include "tdmo_consts.vh"

module tdmo_mapper #(
	parameter LOS_CYCLES = `TDMO_LOS_MS * `TDMO_CLK_KHZ,
	parameter TIMER_W = 27,
	parameter DEA_SUPERFRAMES = `TDMO_DEA_SUPERFRAMES
) (
	input wire clk_i,
	input wire rst_i,
	// classic wishbone slave
	input wire wb_cyc_i,
	input wire wb_stb_i,
	input wire wb_we_i,
	input wire [31:0] wb_adr_i,
	input wire [31:0] wb_dat_i,
	input wire [3:0] wb_sel_i,
	output reg [31:0] wb_dat_o,
	output wire wb_ack_o,
	// system tdm port, octets 6, 7, 8 of each frame
	input wire sys_frame_i,
	input wire [7:0] sys_overhead_octet_a_i,
	input wire [7:0] sys_overhead_octet_b_i,
	input wire [7:0] sys_control_octet_i,
	output reg sys_frame_o,
	output reg [7:0] sys_overhead_octet_a_o,
	output reg [7:0] sys_overhead_octet_b_o,
	output reg [7:0] status_octet_o,
	// line side overhead bits
	input wire line_frame_i,
	input wire [7:0] line_overhead_octet_a_i,
	input wire [7:0] line_overhead_octet_b_i,
	input wire line_crc_error_i,
	input wire line_superframe_i,
	output reg line_frame_o,
	output reg [7:0] line_overhead_octet_a_o,
	output reg [7:0] line_overhead_octet_b_o,
	// transceiver core status
	input wire startup_i,
	input wire tone_detect_i,
	input wire in_frame_i,
	input wire deactivated_i,
	output wire line_tx_enable_o,
	output wire idle_o
);

reg ack;
reg [31:0] ctrl;
reg nebe;
reg active;
reg echo_bit;
reg startup_req_n;
reg local_deact_req;
reg in_frame_q;
reg deactivated_q;
reg [7:0] next_line_a;
reg [7:0] next_line_b;
reg [7:0] next_sys_a;
reg [7:0] next_status;
wire line_end;
wire merge_sel;
wire wb_req;
wire [`TDMO_ADDR_W-1:0] reg_adr;
wire timer_start;
wire timer_running;
wire timer_expired;
wire dea_sending;
wire dea_idle;
wire [31:0] stat_word;

assign line_end = ctrl[`TDMO_CTRL_LINE_END];
assign merge_sel = ctrl[`TDMO_CTRL_MERGE];
assign wb_req = wb_cyc_i & wb_stb_i;
assign reg_adr = wb_adr_i[`TDMO_ADDR_W-1:0];
assign wb_ack_o = ack;

// byte-lane merge used by every writable register
function [31:0] lane_merge;
	input [31:0] old;
	input [31:0] new_val;
	input [3:0] sel;
	integer i;
	begin
		lane_merge = old;
		for (i = 0; i < 4; i = i + 1) begin
			if (sel[i]) begin
				lane_merge[i*8 +: 8] = new_val[i*8 +: 8];
			end
		end
	end
endfunction

// one wait state: ack follows the request edge and drops the cycle after
always @(posedge clk_i) begin
	if (rst_i) begin
		ack <= 1'b0;
		ctrl <= `TDMO_CTRL_RESET;
		wb_dat_o <= 32'h0000_0000;
	end else begin
		ack <= wb_req & ~ack;
		if (wb_req & ~ack) begin
			if (wb_we_i) begin
				if (reg_adr == `TDMO_REG_CTRL) begin
					ctrl <= lane_merge(ctrl, wb_dat_i, wb_sel_i);
				end
			end else begin
				if (reg_adr == `TDMO_REG_CTRL) begin
					wb_dat_o <= ctrl;
				end else if (reg_adr == `TDMO_REG_STAT) begin
					wb_dat_o <= stat_word;
				end else if (reg_adr == `TDMO_REG_OVH) begin
					wb_dat_o <= {8'h00, status_octet_o,
						sys_overhead_octet_b_o, sys_overhead_octet_a_o};
				end else begin
					wb_dat_o <= 32'h0000_0000;
				end
			end
		end
	end
end

assign stat_word = {20'h00000, timer_running, dea_idle, dea_sending, active,
	status_octet_o};

// control octet fields are held from frame to frame
always @(posedge clk_i) begin
	if (rst_i) begin
		echo_bit <= 1'b1;
		startup_req_n <= 1'b1;
		local_deact_req <= 1'b0;
	end else if (sys_frame_i) begin
		echo_bit <= sys_control_octet_i[`TDMO_C_ECHO];
		startup_req_n <= sys_control_octet_i[`TDMO_C_STARTUP];
		local_deact_req <= sys_control_octet_i[`TDMO_C_LDEA];
	end
end

// latch checksum result per line frame
always @(posedge clk_i) begin
	if (rst_i) begin
		nebe <= 1'b1;
	end else if (line_frame_i) begin
		nebe <= ~line_crc_error_i;
	end
end

always @(posedge clk_i) begin
	if (rst_i) begin
		in_frame_q <= 1'b0;
		deactivated_q <= 1'b0;
	end else begin
		in_frame_q <= in_frame_i;
		deactivated_q <= deactivated_i;
	end
end

assign timer_start = (in_frame_q & ~in_frame_i) | (deactivated_i & ~deactivated_q);

tdmo_los_timer #(
	.CYCLES(LOS_CYCLES),
	.W(TIMER_W)
) u_los_timer (
	.clk_i(clk_i),
	.rst_i(rst_i),
	.start_i(timer_start),
	.cancel_i(in_frame_i & ~deactivated_i),
	.running_o(timer_running),
	.expired_o(timer_expired)
);

// set wins over the expiry clear in the same cycle
always @(posedge clk_i) begin
	if (rst_i) begin
		active <= 1'b0;
	end else if (tone_detect_i | ~startup_req_n) begin
		active <= 1'b1;
	end else if (timer_expired) begin
		active <= 1'b0;
	end
end

tdmo_deact_seq #(
	.SUPERFRAMES(DEA_SUPERFRAMES)
) u_deact_seq (
	.clk_i(clk_i),
	.rst_i(rst_i),
	.request_i(line_end & (local_deact_req | ctrl[`TDMO_CTRL_LDEA])),
	.superframe_i(line_superframe_i),
	.sending_o(dea_sending),
	.idle_o(dea_idle)
);

assign line_tx_enable_o = ~dea_idle;
assign idle_o = dea_idle;

// toward the line: system octets pass, with the documented overrides
always @* begin
	// test mode, cold start, activity pass
	next_line_a = sys_overhead_octet_a_i;
	next_line_b = sys_overhead_octet_b_i;
	if (line_end) begin
		next_line_a[`TDMO_A_PWR_DEA] = sys_overhead_octet_a_i[`TDMO_A_PWR_DEA] & ~dea_sending;
	end
	if (merge_sel) begin
		next_line_b[`TDMO_B_FEBE] = sys_overhead_octet_b_i[`TDMO_B_FEBE] & nebe;
	end
end

// toward the system: received octets pass except activation during start-up
always @* begin
	// power status and deactivate pass to system
	next_sys_a = line_overhead_octet_a_i;
	if (startup_i) begin
		next_sys_a[`TDMO_A_ACT] = 1'b0;
	end
end

always @* begin
	next_status = `TDMO_OCTET_ONES;
	next_status[`TDMO_BIT1] = nebe;
	next_status[`TDMO_BIT2] = active;
	next_status[`TDMO_BIT3] = 1'b0;
	next_status[`TDMO_BIT5] = in_frame_i;
	next_status[`TDMO_BIT7] = echo_bit;
end

always @(posedge clk_i) begin
	if (rst_i) begin
		sys_frame_o <= 1'b0;
		line_frame_o <= 1'b0;
		sys_overhead_octet_a_o <= `TDMO_OCTET_ONES;
		sys_overhead_octet_b_o <= `TDMO_OCTET_ONES;
		line_overhead_octet_a_o <= `TDMO_OCTET_ONES;
		line_overhead_octet_b_o <= `TDMO_OCTET_ONES;
		status_octet_o <= `TDMO_OCTET_ONES;
	end else begin
		sys_frame_o <= line_frame_i;
		line_frame_o <= sys_frame_i;
		status_octet_o <= next_status;
		if (line_frame_i) begin
			sys_overhead_octet_a_o <= next_sys_a;
			sys_overhead_octet_b_o <= line_overhead_octet_b_i;
		end else if (startup_i) begin
			// activation must read pending even between frames
			sys_overhead_octet_a_o[`TDMO_A_ACT] <= 1'b0;
		end
		if (sys_frame_i) begin
			line_overhead_octet_a_o <= next_line_a;
			line_overhead_octet_b_o <= next_line_b;
		end
	end
end

endmodule
`default_nettype wire

// >>> verilog/tdmo_consts.vh
`ifndef TDMO_CONSTS_VH
`define TDMO_CONSTS_VH

// bit n of an octet (n = 1 first on the wire) sits at index 8 - n
`define TDMO_BIT1 7
`define TDMO_BIT2 6
`define TDMO_BIT3 5
`define TDMO_BIT4 4
`define TDMO_BIT5 3
`define TDMO_BIT6 2
`define TDMO_BIT7 1
`define TDMO_BIT8 0

// sixth octet fields
`define TDMO_A_ACT `TDMO_BIT5
`define TDMO_A_PWR_DEA `TDMO_BIT8
// seventh octet fields
`define TDMO_B_FEBE `TDMO_BIT2
// control octet fields
`define TDMO_C_STARTUP `TDMO_BIT2
`define TDMO_C_LDEA `TDMO_BIT5
`define TDMO_C_ECHO `TDMO_BIT7

`define TDMO_OCTET_ONES 8'hff

// register word offsets (byte addresses)
`define TDMO_REG_CTRL 4'h0
`define TDMO_REG_STAT 4'h4
`define TDMO_REG_OVH 4'h8
`define TDMO_ADDR_W 4

// control register fields
`define TDMO_CTRL_LINE_END 0
`define TDMO_CTRL_MERGE 1
`define TDMO_CTRL_LDEA 2
`define TDMO_CTRL_RESET 32'h0000_0000

// status register fields
`define TDMO_STAT_OCTET_LSB 0
`define TDMO_STAT_ACTIVE 8
`define TDMO_STAT_DEACT 9
`define TDMO_STAT_IDLE 10
`define TDMO_STAT_TIMER 11

// timing
`define TDMO_LOS_MS 480
`define TDMO_CLK_KHZ 250000
`define TDMO_DEA_SUPERFRAMES 3

`endif

// >>> verilog/tdmo_los_timer.v
`timescale 1ns/1ns
`default_nettype none
`include "tdmo_consts.vh"

module tdmo_los_timer #(
	parameter CYCLES = `TDMO_LOS_MS * `TDMO_CLK_KHZ,
	parameter W = 27
) (
	input wire clk_i,
	input wire rst_i,
	input wire start_i,
	input wire cancel_i,
	output reg running_o,
	output reg expired_o
);

reg [W-1:0] count;

// a new start while running restarts the full interval
always @(posedge clk_i) begin
	if (rst_i) begin
		count <= {W{1'b0}};
		running_o <= 1'b0;
		expired_o <= 1'b0;
	end else begin
		expired_o <= 1'b0;
		if (start_i) begin
			count <= CYCLES[W-1:0] - 1'b1;
			running_o <= 1'b1;
		end else if (cancel_i) begin
			running_o <= 1'b0;
		end else if (running_o) begin
			if (count == {W{1'b0}}) begin
				running_o <= 1'b0;
				expired_o <= 1'b1;
			end else begin
				count <= count - 1'b1;
			end
		end
	end
end

endmodule
`default_nettype wire

// >>> verilog/tdmo_deact_seq.v
`timescale 1ns/1ns
`default_nettype none
`include "tdmo_consts.vh"

module tdmo_deact_seq #(
	parameter SUPERFRAMES = `TDMO_DEA_SUPERFRAMES
) (
	input wire clk_i,
	input wire rst_i,
	input wire request_i,
	input wire superframe_i,
	output reg sending_o,
	output reg idle_o
);

localparam S_RUN = 2'b00;
localparam S_WARN = 2'b01;
localparam S_IDLE = 2'b10;

reg [1:0] state;
reg [3:0] frames;

// the frame in progress at the request counts too, giving three or four
always @(posedge clk_i) begin
	if (rst_i) begin
		state <= S_RUN;
		frames <= 4'h0;
		sending_o <= 1'b0;
		idle_o <= 1'b0;
	end else begin
		case (state)
		S_RUN: begin
			if (request_i) begin
				state <= S_WARN;
				frames <= 4'h0;
				sending_o <= 1'b1;
			end
		end
		S_WARN: begin
			if (superframe_i) begin
				if (frames == SUPERFRAMES[3:0]) begin
					state <= S_IDLE;
					sending_o <= 1'b0;
					idle_o <= 1'b1;
				end else begin
					frames <= frames + 4'h1;
				end
			end
		end
		S_IDLE: begin
			if (!request_i) begin
				state <= S_RUN;
				idle_o <= 1'b0;
			end
		end
		default: begin
			state <= S_RUN;
			sending_o <= 1'b0;
			idle_o <= 1'b0;
		end
		endcase
	end
end

endmodule
`default_nettype wire

// >>> tb/tdmo_sysctl.sv
`timescale 1ns/1ns
`default_nettype none
// system controller: octets are only meaningful with the strobe
module tdmo_sysctl (
	input wire logic clk_i,
	input wire logic send_i,
	input wire logic line_end_i,
	input wire logic [7:0] a_i,
	input wire logic [7:0] b_i,
	input wire logic [2:0] ctl_i,
	output logic frame_o,
	output logic [7:0] a_o,
	output logic [7:0] b_o,
	output logic [7:0] c_o
);
	initial frame_o = 0;
	always @(posedge clk_i) begin
		frame_o <= send_i;
		if (send_i) begin
			a_o <= a_i | 8'h06;
			// reserved and indicator bits at 1
			b_o <= b_i | (line_end_i ? 8'hbc : 8'h85);
			// ctl_i is {start-up request, local deactivation, echo}
			c_o <= {1'b1, ctl_i[2], 2'b10, ctl_i[1], 1'b1, ctl_i[0], 1'b0};
		end else begin
			// lines are inverted every cycle between frames, so the held value shows only every other cycle
			a_o <= ~a_o;
			b_o <= ~b_o;
			c_o <= ~c_o;
		end
	end
endmodule
`default_nettype wire

// >>> tb/tdmo_asserts.sv
`timescale 1ns/1ns
`default_nettype none
module tdmo_asserts (
	input wire clk_i,
	input wire rst_i,
	input wire wb_cyc_i,
	input wire wb_stb_i,
	input wire wb_ack_o,
	input wire sys_frame_i,
	input wire [7:0] sys_control_octet_i,
	input wire line_frame_i,
	input wire line_crc_error_i,
	input wire [7:0] line_overhead_octet_b_i,
	input wire in_frame_i,
	input wire line_frame_o,
	input wire sys_frame_o,
	input wire [7:0] sys_overhead_octet_b_o,
	input wire [7:0] status_octet_o
);
	default clocking @(posedge clk_i); endclocking
	default disable iff (rst_i);
	a_ack_single: assert property (wb_ack_o |=> !wb_ack_o)
		else $error("ack held");
	a_ack_answer: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
		else $error("no ack");
	a_fwd_strobe: assert property (sys_frame_i |=> line_frame_o)
		else $error("line strobe missing");
	a_rev_strobe: assert property (line_frame_i |=> sys_frame_o)
		else $error("sys strobe missing");
	a_octet_back: assert property (line_frame_i |=>
		sys_overhead_octet_b_o == $past(line_overhead_octet_b_i)) else $error("octet b lost");
	a_fixed_status: assert property (!$past(rst_i) |->
		status_octet_o[4] && status_octet_o[2] && status_octet_o[0]) else $error("status ones");
	a_frame_follow: assert property (!$past(rst_i) |->
		status_octet_o[3] == $past(in_frame_i)) else $error("frame bit");
	a_crc_error: assert property (line_frame_i && line_crc_error_i |->
		##[1:2] !status_octet_o[7]) else $error("near-end error");
	a_echo_back: assert property (sys_frame_i && sys_control_octet_i[1] |->
		##[1:2] status_octet_o[1]) else $error("echo bit");
endmodule
bind tdmo_mapper tdmo_asserts u_chk (.clk_i, .rst_i, .wb_cyc_i, .wb_stb_i, .wb_ack_o,
	.sys_frame_i, .sys_control_octet_i, .line_frame_i, .line_crc_error_i,
	.line_overhead_octet_b_i, .in_frame_i, .line_frame_o, .sys_frame_o,
	.sys_overhead_octet_b_o, .status_octet_o);
`default_nettype wire

// >>> tb/tb.sv
`timescale 1ns/1ns
`default_nettype none
`include "tdmo_consts.vh"
module tb;
	logic clk_i = 0, rst_i = 1, wb_cyc_i = 0, wb_stb_i = 0, wb_we_i = 0, send = 0, lend = 0;
	logic [31:0] wb_adr_i = 0, wb_dat_i = 0, wb_dat_o, q;
	logic [3:0] wb_sel_i = 4'hf;
	logic wb_ack_o, sys_frame_i, sys_frame_o, line_frame_o, line_tx_enable_o, idle_o;
	logic [7:0] sys_overhead_octet_a_i, sys_overhead_octet_b_i, sys_control_octet_i;
	logic [7:0] sys_overhead_octet_a_o, sys_overhead_octet_b_o, status_octet_o;
	logic [7:0] line_overhead_octet_a_o, line_overhead_octet_b_o, da = 0, db = 0;
	logic line_frame_i = 0, line_crc_error_i = 0, line_superframe_i = 0, startup_i = 0;
	logic tone_detect_i = 0, in_frame_i = 1, deactivated_i = 0;
	logic [7:0] line_overhead_octet_a_i = 0, line_overhead_octet_b_i = 0;
	logic [2:0] ctl = 3'h4;
	int err_total = 0, n_tests = 0, cyc_cnt = 0;
	always #2 clk_i = ~clk_i;
	tdmo_mapper #(.LOS_CYCLES(50)) dut (.clk_i, .rst_i, .wb_cyc_i, .wb_stb_i, .wb_we_i,
		.wb_adr_i, .wb_dat_i, .wb_sel_i, .wb_dat_o, .wb_ack_o, .sys_frame_i,
		.sys_overhead_octet_a_i, .sys_overhead_octet_b_i, .sys_control_octet_i, .sys_frame_o,
		.sys_overhead_octet_a_o, .sys_overhead_octet_b_o, .status_octet_o, .line_frame_i,
		.line_overhead_octet_a_i, .line_overhead_octet_b_i, .line_crc_error_i,
		.line_superframe_i, .line_frame_o, .line_overhead_octet_a_o, .line_overhead_octet_b_o,
		.startup_i, .tone_detect_i, .in_frame_i, .deactivated_i, .line_tx_enable_o, .idle_o);
	tdmo_sysctl u_sys (.clk_i, .send_i(send), .line_end_i(lend), .a_i(da), .b_i(db),
		.ctl_i(ctl), .frame_o(sys_frame_i), .a_o(sys_overhead_octet_a_i),
		.b_o(sys_overhead_octet_b_i), .c_o(sys_control_octet_i));
	task chk(input logic [31:0] got, input logic [31:0] exp);
		n_tests++;
		if (got !== exp) begin
			err_total++;
			$display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task end_sim;
		$display("tests=%0d errors=%0d", n_tests, err_total);
		if (err_total == 0 && n_tests > 0) $display("*** PASS ***");
		else $display("*** FAIL ***");
		$finish;
	endtask
	task wb(input logic w, input logic [3:0] a, input logic [31:0] d);
		int k;
		k = 0;
		@(posedge clk_i);
		wb_cyc_i <= 1;
		wb_stb_i <= 1;
		wb_we_i <= w;
		wb_adr_i <= {28'h0, a};
		wb_dat_i <= d;
		do @(posedge clk_i);
		while (wb_ack_o !== 1'b1 && ++k < 20);
		q = wb_dat_o;
		chk(k < 20, 1);
		wb_cyc_i <= 0;
		wb_stb_i <= 0;
	endtask
	task sfr(input logic [7:0] a, input logic [7:0] b, input logic [2:0] c);
		@(posedge clk_i);
		send <= 1;
		da <= a;
		db <= b;
		ctl <= c;
		@(posedge clk_i);
		send <= 0;
		repeat (3) @(posedge clk_i);
	endtask
	task lfr(input logic [7:0] a, input logic [7:0] b, input logic e);
		@(posedge clk_i);
		line_frame_i <= 1;
		line_overhead_octet_a_i <= a;
		line_overhead_octet_b_i <= b;
		line_crc_error_i <= e;
		@(posedge clk_i);
		line_frame_i <= 0;
		line_overhead_octet_a_i <= ~a;
		line_overhead_octet_b_i <= ~b;
		repeat (3) @(posedge clk_i);
	endtask
	task t_regs;
		wb(0, `TDMO_REG_STAT, 0);
		chk(q[11:0], 12'h09f);
		wb(1, 4'hc, 32'hffff);
		wb(0, 4'hc, 0);
		chk(q, 0);
		wb(1, `TDMO_REG_CTRL, 32'h3);
		wb(0, `TDMO_REG_CTRL, 0);
		chk(q, 32'h3);
	endtask
	task t_net;
		wb(1, `TDMO_REG_CTRL, 0);
		sfr(8'h5a, 8'h3c, 3'h4);
		chk(line_overhead_octet_a_o, 8'h5e);
		chk(line_overhead_octet_b_o, 8'hbd);
		sfr(8'h00, 8'h00, 3'h4);
		chk(line_overhead_octet_a_o, 8'h06);
		chk(line_overhead_octet_b_o, 8'h85);
	endtask
	task t_line;
		lend <= 1;
		wb(1, `TDMO_REG_CTRL, 32'h1);
		sfr(8'ha1, 8'h42, 3'h4);
		chk(line_overhead_octet_a_o, 8'ha7);
		chk(line_overhead_octet_b_o, 8'hfe);
		sfr(8'ha0, 8'h00, 3'h4);
		chk(line_overhead_octet_a_o, 8'ha6);
		startup_i <= 1;
		lfr(8'h3b, 8'h6d, 0);
		chk(sys_overhead_octet_a_o, 8'h33);
		chk(sys_overhead_octet_b_o, 8'h6d);
		startup_i <= 0;
		lfr(8'h08, 8'h92, 0);
		chk(sys_overhead_octet_a_o, 8'h08);
	endtask
	task t_status;
		lend <= 0;
		lfr(8'hff, 8'hff, 1);
		chk(status_octet_o[7], 0);
		wb(1, `TDMO_REG_CTRL, 32'h2);
		sfr(8'hff, 8'hff, 3'h4);
		chk(line_overhead_octet_b_o, 8'hbf);
		lfr(8'hff, 8'hff, 0);
		sfr(8'hff, 8'hff, 3'h5);
		chk(line_overhead_octet_b_o, 8'hff);
		chk(status_octet_o[1], 1);
		sfr(8'hff, 8'hff, 3'h0);
		chk(status_octet_o[1], 0);
		// the start-up request reaches the status octet one cycle after the echo bit
		@(posedge clk_i);
		chk(status_octet_o[6], 1);
		sfr(8'hff, 8'hff, 3'h4);
		in_frame_i <= 0;
		repeat (40) @(posedge clk_i);
		chk(status_octet_o[6:3], 4'ha);
		repeat (20) @(posedge clk_i);
		chk(status_octet_o[6], 0);
		tone_detect_i <= 1;
		@(posedge clk_i);
		tone_detect_i <= 0;
		in_frame_i <= 1;
		repeat (2) @(posedge clk_i);
		chk(status_octet_o[6], 1);
	endtask
	task t_deact;
		lend <= 1;
		wb(1, `TDMO_REG_CTRL, 32'h1);
		sfr(8'hff, 8'hff, 3'h6);
		// the request is taken with one frame, so the warning shows in the next frame
		sfr(8'hff, 8'hff, 3'h6);
		chk(line_overhead_octet_a_o, 8'hfe);
		for (int i = 1; i <= 5; i++) begin
			@(posedge clk_i);
			line_superframe_i <= 1;
			@(posedge clk_i);
			line_superframe_i <= 0;
			repeat (8) @(posedge clk_i);
			if (i == 2) chk(idle_o, 0);
		end
		chk({idle_o, line_tx_enable_o}, 2'b10);
	endtask
	always @(posedge clk_i) begin
		cyc_cnt++;
		if (cyc_cnt == 5000) begin
			err_total++;
			end_sim;
		end
	end
	initial begin
		repeat (3) @(posedge clk_i);
		rst_i <= 0;
		t_regs;
		t_net;
		t_line;
		t_status;
		t_deact;
		end_sim;
	end
endmodule
`default_nettype wire
